//--- verilog/scocd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module scocd_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_we,
  input wire logic [7:0] command_code,
  input wire logic [7:0] feature_cur,
  input wire logic [7:0] feature_prev,
  input wire logic [7:0] count_cur,
  input wire logic [7:0] count_prev,
  input wire logic stream_supported,
  input wire logic [15:0] unit_us,
  input wire logic power_on_clear,
  input wire logic set_violation,
  input wire logic [7:0] set_word,
  input wire logic [7:0] set_bit,
  input wire logic [2:0] query_id,
  output logic [7:0] error_flags,
  output logic [7:0] status_flags,
  output logic [7:0] transfer_count,
  output logic [7:0] address_mid_byte,
  output logic [7:0] address_high_byte,
  output logic cmd_done,
  output logic overlay_frozen,
  output logic overlay_restore,
  output logic overlay_identify,
  output logic overlay_set,
  output logic [7:0] stream_valid,
  output logic query_dir,
  output logic [23:0] query_completion_time_limit,
  output logic [15:0] query_alloc
);
  import scocd_pkg::*;

  // ---------------------------------------------------------------
  // Command latch and decode
  // ---------------------------------------------------------------
  scocd_state_type state_q, state_d;
  logic [7:0] cmd_q, feat_q, featp_q, cnt_q, cntp_q;
  wire is_stream = cmd_q == CMD_CONFIG_STREAM;
  wire is_overlay = cmd_q == CMD_OVERLAY;
  wire req_add = feat_q[ADD_BIT];
  wire req_dir = feat_q[DIR_BIT];
  wire [2:0] req_id = feat_q[ID_MSB:0];
  wire [15:0] req_alloc = {cntp_q, cnt_q};
  wire ovl_restore = feat_q == OVL_RESTORE;
  wire ovl_freeze = feat_q == OVL_FREEZE;
  wire ovl_ident = feat_q == OVL_IDENTIFY;
  wire ovl_set = feat_q == OVL_SET;
  wire ovl_reserved = !(ovl_restore || ovl_freeze || ovl_ident || ovl_set);
  logic frozen_q;
  logic [7:0] valid_q;
  wire id_valid = valid_q[req_id];

  // ---------------------------------------------------------------
  // Abort decisions
  // ---------------------------------------------------------------
  wire stream_abort = !stream_supported
    || (!req_add && !id_valid);
  wire ovl_frozen_abort = frozen_q;
  wire ovl_set_abort = ovl_set && set_violation && !frozen_q;
  wire overlay_abort = ovl_reserved || ovl_frozen_abort || ovl_set_abort;
  wire other_cmd = !is_stream && !is_overlay;
  wire abort_now = (is_stream && stream_abort) || (is_overlay && overlay_abort) || other_cmd;
  wire exec = state_q == SCOCD_EXEC;
  wire take = cmd_we && state_q == SCOCD_IDLE;
  wire stream_commit = exec && is_stream && !stream_abort;
  wire overlay_ok = exec && is_overlay && !overlay_abort;

  // ---------------------------------------------------------------
  // Default completion limit with floor
  // ---------------------------------------------------------------
  logic [23:0] product;
  scocd_mul u_mul (
    .clk(clk),
    .rst(rst),
    // Multiply the bus byte on the take edge so the product is ready at the table write
    .factor(take ? feature_prev : featp_q),
    .unit_us(unit_us),
    .product(product)
  );
  wire [23:0] completion_time_limit_floor = product < MIN_COMPLETION_TIME_LIMIT_US ? MIN_COMPLETION_TIME_LIMIT_US : product;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SCOCD_IDLE: begin
        if (cmd_we) begin
          state_d = SCOCD_EXEC;
        end
      end
      SCOCD_EXEC: begin
        state_d = SCOCD_DONE;
      end
      SCOCD_DONE: begin
        state_d = SCOCD_IDLE;
      end
      default: begin
        state_d = SCOCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SCOCD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Latch the task file when the command register is written
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= 8'h00;
      feat_q <= 8'h00;
      featp_q <= 8'h00;
      cnt_q <= 8'h00;
      cntp_q <= 8'h00;
    end else if (cmd_we && state_q == SCOCD_IDLE) begin
      cmd_q <= command_code;
      feat_q <= feature_cur;
      featp_q <= feature_prev;
      cnt_q <= count_cur;
      cntp_q <= count_prev;
    end
  end

  // ---------------------------------------------------------------
  // Stream table
  // ---------------------------------------------------------------
  logic [NUM_STREAMS-1:0] dir_q;
  logic [23:0] completion_time_limit_q [NUM_STREAMS];
  logic [15:0] alloc_q [NUM_STREAMS];
  genvar g;
  generate
    for (g = 0; g < NUM_STREAMS; g++) begin : g_stream
      wire hit = stream_commit && req_id == 3'(g);
      always_ff @(posedge clk) begin
        if (rst) begin
          valid_q[g] <= 1'b0;
          dir_q[g] <= 1'b0;
          completion_time_limit_q[g] <= MIN_COMPLETION_TIME_LIMIT_US;
          alloc_q[g] <= 16'h0000;
        end else if (hit && req_add) begin
          valid_q[g] <= 1'b1;
          dir_q[g] <= req_dir;
          completion_time_limit_q[g] <= completion_time_limit_floor;
          alloc_q[g] <= req_alloc;
        end else if (hit) begin
          valid_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Default applied by the stream engine when a command carries a zero limit,
  // timed from command write to final completion
  always_ff @(posedge clk) begin
    if (rst) begin
      query_dir <= 1'b0;
      query_completion_time_limit <= 24'h000000;
      query_alloc <= 16'h0000;
      stream_valid <= 8'h00;
    end else begin
      query_dir <= dir_q[query_id];
      query_completion_time_limit <= completion_time_limit_q[query_id];
      query_alloc <= alloc_q[query_id];
      stream_valid <= valid_q;
    end
  end

  // ---------------------------------------------------------------
  // Overlay state; freeze survives rst, cleared only at power-on
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (power_on_clear) begin
      frozen_q <= 1'b0;
    end else if (overlay_ok && ovl_freeze) begin
      frozen_q <= 1'b1;
    end
  end

  // Lock indication follows the lock itself, so it holds through rst
  always_ff @(posedge clk) begin
    overlay_frozen <= frozen_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overlay_restore <= 1'b0;
      overlay_identify <= 1'b0;
      overlay_set <= 1'b0;
    end else begin
      overlay_restore <= overlay_ok && ovl_restore;
      overlay_identify <= overlay_ok && ovl_ident;
      overlay_set <= overlay_ok && ovl_set;
    end
  end

  // ---------------------------------------------------------------
  // Error, status and returned registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      error_flags <= ERROR_RESET;
      status_flags <= STATUS_RESET;
      transfer_count <= 8'h00;
      address_mid_byte <= 8'h00;
      address_high_byte <= 8'h00;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      if (cmd_we && state_q == SCOCD_IDLE) begin
        status_flags <= 8'h00;
        status_flags[ST_BSY_BIT] <= 1'b1;
      end else if (exec) begin
        cmd_done <= 1'b1;
        error_flags <= 8'h00;
        error_flags[ERR_ABORT_BIT] <= abort_now;
        status_flags <= 8'h00;
        status_flags[ST_RDY_BIT] <= 1'b1;
        status_flags[ST_DSC_BIT] <= 1'b1;
        status_flags[ST_ERR_BIT] <= abort_now;
        status_flags[ST_DRQ_BIT] <= overlay_ok && (ovl_ident || ovl_set);
        if (is_overlay && ovl_frozen_abort && !ovl_reserved) begin
          transfer_count <= REASON_FROZEN;
          address_mid_byte <= 8'h00;
          address_high_byte <= 8'h00;
        end else if (ovl_set_abort && is_overlay) begin
          transfer_count <= REASON_SET_REFUSED;
          address_mid_byte <= set_bit;
          address_high_byte <= set_word;
        end
      end
    end
  end
endmodule // scocd_decoder
`default_nettype wire

//--- verilog/scocd_pkg.sv
// Functional notes
// - Command 51h configures one stream
// - Feature bit 7: add or remove
// - Feature bit 6: read or write direction
// - Add on valid identifier overwrites stored parameters
// - Aborted configure keeps old parameters
// - Abort when streaming unsupported
// - Abort removal of never-configured identifier
// - Default limit is previous feature times units
// - Zero limit later uses stored default
// - Limit runs from command write to completion
// - Limit below minimum raised to minimum
// - Command B1h is overlay, feature selects
// - C0h restore C1h freeze C2h identify C3h set
// - Restore cancels overlay set changes
// - Overlay violation reports reason, word, bit
// - Freeze lock aborts later overlay commands
package scocd_pkg;
  localparam logic [7:0] CMD_CONFIG_STREAM = 8'h51;
  localparam logic [7:0] CMD_OVERLAY = 8'hB1;
  localparam logic [7:0] OVL_RESTORE = 8'hC0;
  localparam logic [7:0] OVL_FREEZE = 8'hC1;
  localparam logic [7:0] OVL_IDENTIFY = 8'hC2;
  localparam logic [7:0] OVL_SET = 8'hC3;
  localparam int ADD_BIT = 7;
  localparam int DIR_BIT = 6;
  localparam int ID_MSB = 2;
  localparam int NUM_STREAMS = 8;
  localparam int ERR_ABORT_BIT = 2;
  localparam int ST_ERR_BIT = 0;
  localparam int ST_DSC_BIT = 4;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_BSY_BIT = 7;
  localparam int ST_DRQ_BIT = 3;
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  localparam logic [15:0] UNIT_US_RESET = 16'h0001;
  localparam logic [23:0] MIN_COMPLETION_TIME_LIMIT_US = 24'h0003E8;
  localparam logic [15:0] CAP_RESET = 16'hFFFF;
  localparam logic [7:0] REASON_SET_REFUSED = 8'h01;
  localparam logic [7:0] REASON_FROZEN = 8'h02;
  typedef enum logic [1:0] {
    SCOCD_IDLE = 2'b00,
    SCOCD_EXEC = 2'b01,
    SCOCD_DONE = 2'b11
  } scocd_state_type;
endpackage : scocd_pkg

//--- verilog/scocd_mul.sv
`timescale 1ns/1ns
`default_nettype none
// Registered product of the previous feature byte and the time unit
module scocd_mul (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] factor,
  input wire logic [15:0] unit_us,
  output logic [23:0] product
);
  always_ff @(posedge clk) begin
    if (rst) begin
      product <= 24'h000000;
    end else begin
      product <= 24'(factor) * 24'(unit_us);
    end
  end
endmodule // scocd_mul
`default_nettype wire

//--- tb/scocd_host.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Host side of the task file
// ----------------------------------------
module scocd_host (
  input wire logic clk,
  input wire logic cmd_done,
  output logic cmd_we,
  output logic [7:0] command_code,
  output logic [7:0] feature_cur,
  output logic [7:0] feature_prev,
  output logic [7:0] count_cur,
  output logic [7:0] count_prev
);
  initial begin
    cmd_we = 1'b0;
    {command_code, feature_cur, feature_prev, count_cur, count_prev} = '0;
  end
  // Caller packs the identifier into bits 2:0 and the allocation unit into the two counts
  task automatic send(input logic [39:0] tf, output logic seen);
    @(posedge clk);
    #1 cmd_we = 1'b1;
    {command_code, feature_cur, feature_prev, count_cur, count_prev} = tf;
    @(posedge clk);
    #1 cmd_we = 1'b0;
    // Released bytes show the inverse, never the last value
    {command_code, feature_cur, feature_prev, count_cur, count_prev} = ~tf;
    seen = 1'b0;
    for (int i = 0; i < 6 && !seen; i++) begin
      @(posedge clk);
      #1 seen = (cmd_done === 1'b1);
    end
  endtask
endmodule // scocd_host
`default_nettype wire

//--- tb/scocd_decoder_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module scocd_decoder_asserts
  import scocd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_we,
  input wire logic [7:0] command_code,
  input wire logic [7:0] feature_cur,
  input wire logic stream_supported,
  input wire logic [7:0] error_flags,
  input wire logic [7:0] status_flags,
  input wire logic cmd_done,
  input wire logic overlay_frozen,
  input wire logic overlay_restore,
  input wire logic [7:0] stream_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Not busy and not in the completion cycle, when the sequencer is idle
  wire take = cmd_we && !status_flags[ST_BSY_BIT] && !cmd_done;
  wire str = take && command_code == CMD_CONFIG_STREAM;
  wire ovl = take && command_code == CMD_OVERLAY;
  wire abt = cmd_done && error_flags[ERR_ABORT_BIT];
  property p_busy; take |=> status_flags[ST_BSY_BIT]; endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  property p_done; take |-> ##[1:3] cmd_done; endproperty
  a_done: assert property (p_done) else $error("no completion");
  property p_pulse; cmd_done |=> !cmd_done; endproperty
  a_pulse: assert property (p_pulse) else $error("completion not a pulse");
  property p_unsup; str && !stream_supported |-> ##[1:3] abt; endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported not aborted");
  property p_rmv; str && stream_supported && !feature_cur[ADD_BIT] && !stream_valid[feature_cur[ID_MSB:0]]
    |-> ##[1:3] abt; endproperty
  a_rmv: assert property (p_rmv) else $error("bad removal not aborted");
  property p_add; str && stream_supported && feature_cur[ADD_BIT] |-> ##[1:3] cmd_done && !error_flags[ERR_ABORT_BIT];
  endproperty
  a_add: assert property (p_add) else $error("add aborted");
  property p_rsvd; ovl && feature_cur[7:2] != 6'h30 |-> ##[1:3] abt && status_flags[ST_ERR_BIT]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved overlay not aborted");
  property p_frz; ovl && overlay_frozen |-> ##[1:3] abt; endproperty
  a_frz: assert property (p_frz) else $error("frozen overlay not aborted");
  property p_rest; ovl && !overlay_frozen && feature_cur == OVL_RESTORE |-> ##[1:4] overlay_restore; endproperty
  a_rest: assert property (p_rest) else $error("restore not issued");
  c_abt: cover property (take ##[1:3] abt);
  c_rest: cover property (overlay_restore);
  c_frz: cover property (overlay_frozen);
endmodule // scocd_decoder_asserts
bind scocd_decoder scocd_decoder_asserts u_chk (.clk(clk), .rst(rst), .cmd_we(cmd_we), .command_code(command_code),
  .feature_cur(feature_cur), .stream_supported(stream_supported), .error_flags(error_flags),
  .status_flags(status_flags), .cmd_done(cmd_done), .overlay_frozen(overlay_frozen),
  .overlay_restore(overlay_restore), .stream_valid(stream_valid));
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import scocd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sup = 1'b0, poc = 1'b1, viol = 1'b0, seen;
  logic [15:0] unit = 16'h0001;
  logic [7:0] sw = 8'h00, sb = 8'h00;
  logic [2:0] qid = 3'h0;
  logic [7:0] ovl[5] = '{OVL_RESTORE, OVL_IDENTIFY, OVL_SET, 8'hC4, 8'hBF};
  wire logic we, done, frz, rsto, idn, setp, qdir;
  wire logic [7:0] cmd, f0, f1, c0, c1, err, st, tc, amid, ahi, sv;
  wire logic [23:0] qcctl;
  wire logic [15:0] qalloc;
  int error_cnt = 0, checked = 0, cyc = 0;
  bit mv[8], md[8];
  int mc[8], ma[8];
  scocd_host u_host (.clk(clk), .cmd_done(done), .cmd_we(we), .command_code(cmd), .feature_cur(f0),
    .feature_prev(f1), .count_cur(c0), .count_prev(c1));
  scocd_decoder u_dut (.clk(clk), .rst(rst), .cmd_we(we), .command_code(cmd), .feature_cur(f0), .feature_prev(f1),
    .count_cur(c0), .count_prev(c1), .stream_supported(sup), .unit_us(unit), .power_on_clear(poc),
    .set_violation(viol), .set_word(sw), .set_bit(sb), .query_id(qid), .error_flags(err), .status_flags(st),
    .transfer_count(tc), .address_mid_byte(amid), .address_high_byte(ahi), .cmd_done(done), .overlay_frozen(frz),
    .overlay_restore(rsto), .overlay_identify(idn), .overlay_set(setp), .stream_valid(sv), .query_dir(qdir),
    .query_completion_time_limit(qcctl), .query_alloc(qalloc));
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic run(input logic [7:0] k, f, p, a, b, input bit ab);
    u_host.send({k, f, p, a, b}, seen);
    chk(seen === 1'b1 && err[ERR_ABORT_BIT] === ab && st[ST_ERR_BIT] === ab && st[ST_BSY_BIT] === 1'b0, "finish");
  endtask
  task automatic q(input int i);
    logic [7:0] v;
    for (int j = 0; j < 8; j++) v[j] = mv[j];
    qid = 3'(i);
    repeat (2) @(posedge clk);
    #1 chk(sv === v, "valid set");
    if (mv[i]) chk(qdir === md[i] && qcctl === 24'(mc[i]) && qalloc === 16'(ma[i]), "params");
  endtask
  initial begin
    int i, a, c;
    bit d;
    void'($urandom(32'hB5BC5ED0));
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    poc = 1'b0;
    chk(err === ERROR_RESET && st === STATUS_RESET, "reset");
    run(CMD_CONFIG_STREAM, 8'hC5, 8'h10, 8'h01, 8'h00, 1'b1);
    q(5);
    sup = 1'b1;
    unit = 16'($urandom_range(1, 300));
    for (int n = 0; n < 14; n++) begin
      i = $urandom_range(0, 7);
      d = 1'($urandom);
      c = (n == 0) ? 0 : $urandom_range(0, 255);
      a = $urandom;
      run(CMD_CONFIG_STREAM, {1'b1, d, 3'b000, i[2:0]}, 8'(c), a[7:0], a[15:8], 1'b0);
      c = c * int'(unit);
      mv[i] = 1'b1;
      md[i] = d;
      mc[i] = (c < int'(MIN_COMPLETION_TIME_LIMIT_US)) ? int'(MIN_COMPLETION_TIME_LIMIT_US) : c;
      ma[i] = a[15:0];
      q(i);
    end
    repeat (2) begin
      run(CMD_CONFIG_STREAM, {5'h00, i[2:0]}, 8'h00, 8'h00, 8'h00, !mv[i]);
      mv[i] = 1'b0;
      q(i);
    end
    viol = 1'b1;
    sw = 8'($urandom);
    sb = 8'($urandom);
    foreach (ovl[k]) begin
      run(CMD_OVERLAY, ovl[k], 8'h00, 8'h00, 8'h00, ovl[k] != OVL_RESTORE && ovl[k] != OVL_IDENTIFY);
      if (ovl[k] == OVL_SET) chk(tc === REASON_SET_REFUSED && ahi === sw && amid === sb, "reason");
      chk(rsto === (ovl[k] == OVL_RESTORE) && idn === (ovl[k] == OVL_IDENTIFY) && setp === 1'b0, "op");
    end
    viol = 1'b0;
    run(CMD_OVERLAY, OVL_SET, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(setp === 1'b1 && st[ST_DRQ_BIT] === 1'b1, "set accepted");
    run(CMD_OVERLAY, OVL_FREEZE, 8'h00, 8'h00, 8'h00, 1'b0);
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    chk(frz === 1'b1, "lock lost");
    for (int k = 0; k < 4; k++) begin
      run(CMD_OVERLAY, OVL_RESTORE + 8'(k), 8'h00, 8'h00, 8'h00, 1'b1);
      chk(tc === REASON_FROZEN && amid === 8'h00 && ahi === 8'h00, "frozen reason");
    end
    poc = 1'b1;
    @(posedge clk);
    #1 poc = 1'b0;
    @(posedge clk);
    #1 chk(frz === 1'b0, "lock kept");
    run(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    final_report();
  end
endmodule // tb
`default_nettype wire
